// [common/bwecc_defines.svh]
// offsets, field positions, opcodes and reset values of the wrap and ecc status registers
`ifndef BWECC_DEFINES_SVH
`define BWECC_DEFINES_SVH

// command opcodes seen on the command port
`define BWECC_OP_REG_READ     8'h65
`define BWECC_OP_REG_WRITE    8'h71
`define BWECC_OP_BURST_LEN    8'hc0
`define BWECC_OP_ECC_READ_A   8'h18
`define BWECC_OP_ECC_READ_B   8'h19
// quad i/o read and ddr quad i/o read opcodes
`define BWECC_OP_QUAD_IO_READ 8'heb
`define BWECC_OP_DDR_QIO_READ 8'hed

// register addresses used by the generic register commands
`define BWECC_ADDR_CFG_NV     32'h0000_0010
`define BWECC_ADDR_CFG_V      32'h0000_0011

// wrap configuration fields
`define BWECC_WRAP_DIS_BIT    4
`define BWECC_WLEN_MSB        1
`define BWECC_WLEN_LSB        0
`define BWECC_DRV_MSB         7
`define BWECC_DRV_LSB         5
`define BWECC_CFG_RESET       8'h10
`define BWECC_CFG_WMASK       8'hf3

// wrap lengths in bytes
`define BWECC_WRAP_8          8'h08
`define BWECC_WRAP_16         8'h10
`define BWECC_WRAP_32         8'h20
`define BWECC_WRAP_64         8'h40

// ecc status fields
`define BWECC_ECC_CODE_BIT    2
`define BWECC_ECC_DATA_BIT    1
`define BWECC_ECC_OFF_BIT     0
`define BWECC_ECC_RESET       8'h00

`endif

// [common/bwecc_pkg.sv]
// types shared by the wrap configuration and ecc status block
package bwecc_pkg;
   typedef enum logic [1:0] {
      BWECC_ST_IDLE  = 2'b01,
      BWECC_ST_QUERY = 2'b10
   } bwecc_state_t;
endpackage

// [hdl/bwecc_regs.sv]
// burst wrap configuration, drive strength select and ecc unit status registers
//
// Contract
// RULE1: wrap settings apply only to main array reads, never to register or otp reads.
// RULE2: power-on, hardware or software reset copies the non-volatile wrap config to volatile.
// RULE3: wrap, wrap length and drive strength follow the volatile copy in normal operation.
// RULE4: both copies are read by opcode 65h and written by opcode 71h.
// RULE5: the burst length command C0h writes the volatile copy and leaves the non-volatile one.
// RULE6: bit 4 is 0 for wrapped and 1 for sequential reads, non-volatile default 1.
// RULE7: wrap enable affects only the quad i/o read and ddr quad i/o read commands.
// RULE8: bits 1:0 give wrap length 8, 16, 32 or 64 bytes with matching alignment, default 00.
// RULE9: bits 7:5 pick one of eight drive strengths; non-volatile default 000 sets boot strength.
// RULE10: an ecc read (18h or 19h) with a unit address returns that unit's 8-bit status.
// RULE11: ecc status is volatile, read only, hardware set, bits 2:0 default to 0.
// RULE12: ecc status bit 2 is 1 when a single-bit error was corrected in the unit's check code.
// RULE13: ecc status bit 1 is 1 when a single-bit error was corrected in the unit's data.
// RULE14: ecc status bit 0 is 1 when correction is disabled for the unit, 0 when enabled.
// RULE15: the host ignores ecc status bits 7:3, which may read as anything.
// RULE16: a wrapped read runs sequentially and returns to the start of its aligned block.
`timescale 1ns/1ps
`include "bwecc_defines.svh"

module bwecc_regs #(
   parameter int ADDR_W = 32
) (
   input  wire  logic                 ref_clk,
   input  wire  logic                 resetn,
   input  wire  logic                 sw_reset,
   input  wire  logic                 hw_reset_pin_n,
   input  wire  logic                 cmd_valid,
   input  wire  logic [7:0]           cmd_opcode,
   input  wire  logic [ADDR_W-1:0]    cmd_addr,
   input  wire  logic [7:0]           cmd_wdata,
   input  wire  logic                 rd_start,
   input  wire  logic [7:0]           rd_opcode,
   input  wire  logic                 rd_main_array,
   input  wire  logic [ADDR_W-1:0]    rd_addr,
   input  wire  logic                 rd_next,
   input  wire  logic                 ecc_code_fixed,
   input  wire  logic                 ecc_data_fixed,
   input  wire  logic                 ecc_disabled_in,
   output logic                       cmd_busy,
   output logic                       rsp_valid,
   output logic [7:0]                 rsp_data,
   output logic                       ecc_query,
   output logic [ADDR_W-1:0]          ecc_unit_sel,
   output logic [ADDR_W-1:0]          rd_byte_addr,
   output logic                       rd_wrapping,
   output logic [2:0]                 drive_strength_select,
   output logic [2:0]                 boot_drive_strength
);
   import bwecc_pkg::*;

   // mask of the low address bits that stay inside one wrap block
   function automatic logic [ADDR_W-1:0] wrap_mask(input logic [1:0] wl);
      logic [7:0] bytes;
      case (wl)
         2'b00:   bytes = `BWECC_WRAP_8;
         2'b01:   bytes = `BWECC_WRAP_16;
         2'b10:   bytes = `BWECC_WRAP_32;
         default: bytes = `BWECC_WRAP_64;
      endcase
      wrap_mask = ADDR_W'(bytes - 8'h01);
   endfunction

   function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                   input logic              wrap,
                                                   input logic [1:0]        wl);
      logic [ADDR_W-1:0] m;
      logic [ADDR_W-1:0] inc;
      m   = wrap_mask(wl);
      inc = a + ADDR_W'(1);
      next_addr = wrap ? ((a & ~m) | (inc & m)) : inc;
   endfunction

   logic [7:0]        cfg_nv_reg;
   logic [7:0]        cfg_nv_next;
   logic [7:0]        cfg_v_reg;
   logic [7:0]        cfg_v_next;
   logic [7:0]        ecc_status_reg;
   logic [2:0]        hw_sync_reg;
   logic              hw_active_reg;
   bwecc_state_t      state_reg;
   bwecc_state_t      state_next;
   logic              rsp_valid_reg;
   logic              rsp_valid_next;
   logic [7:0]        rsp_data_reg;
   logic [7:0]        rsp_data_next;
   logic              ecc_query_reg;
   logic [ADDR_W-1:0] ecc_unit_sel_reg;
   logic [ADDR_W-1:0] rd_byte_addr_reg;
   logic [ADDR_W-1:0] rd_byte_addr_next;
   logic              rd_wrapping_reg;
   logic              rd_wrapping_next;
   logic [1:0]        rd_wlen_reg;
   logic [1:0]        rd_wlen_next;

   // hardware reset pin level is only trusted once the second and third stages agree
   wire hw_agree      = (hw_sync_reg[1] == hw_sync_reg[2]);
   wire reload_req    = sw_reset || hw_active_reg; // [RULE2]

   // commands are refused while an ecc query is in flight
   wire cmd_ok     = cmd_valid && (state_reg == BWECC_ST_IDLE);
   wire hit_nv     = (cmd_addr == ADDR_W'(`BWECC_ADDR_CFG_NV));
   wire hit_v      = (cmd_addr == ADDR_W'(`BWECC_ADDR_CFG_V));
   wire take_rd    = cmd_ok && (cmd_opcode == `BWECC_OP_REG_READ);
   wire take_wr    = cmd_ok && (cmd_opcode == `BWECC_OP_REG_WRITE);
   wire take_sbl   = cmd_ok && (cmd_opcode == `BWECC_OP_BURST_LEN);
   wire take_ecc   = cmd_ok && ((cmd_opcode == `BWECC_OP_ECC_READ_A) ||
                                (cmd_opcode == `BWECC_OP_ECC_READ_B));
   wire [7:0] wdata_m = cmd_wdata & `BWECC_CFG_WMASK;
   wire [7:0] reg_rdata = hit_nv ? cfg_nv_reg : (hit_v ? cfg_v_reg : 8'h00); // [RULE4]
   wire [7:0] ecc_flags = {5'h00, ecc_code_fixed, ecc_data_fixed,
                           ecc_disabled_in}; // [RULE12] [RULE13] [RULE14]

   // only quad i/o reads of the main array may wrap
   wire quad_op   = (rd_opcode == `BWECC_OP_QUAD_IO_READ) ||
                    (rd_opcode == `BWECC_OP_DDR_QIO_READ); // [RULE7]
   wire wrap_sel  = rd_main_array && quad_op &&
                    !cfg_v_reg[`BWECC_WRAP_DIS_BIT]; // [RULE1] [RULE3] [RULE6]

   assign cfg_nv_next = (take_wr && hit_nv) ? wdata_m : cfg_nv_reg; // [RULE4]
   assign cfg_v_next  = reload_req ? cfg_nv_reg : // [RULE2]
                        ((take_wr && hit_v) || take_sbl) ? wdata_m : cfg_v_reg; // [RULE4] [RULE5]

   // one query cycle follows each accepted ecc read
   always_comb begin
      state_next = BWECC_ST_IDLE;
      case (state_reg)
         BWECC_ST_IDLE: begin
            if (take_ecc) begin
               state_next = BWECC_ST_QUERY;
            end
         end
         BWECC_ST_QUERY: begin
            state_next = BWECC_ST_IDLE;
         end
         default: begin
            state_next = BWECC_ST_IDLE;
         end
      endcase
   end

   assign rsp_valid_next = take_rd || (state_reg == BWECC_ST_QUERY);
   assign rsp_data_next  = (state_reg == BWECC_ST_QUERY) ? ecc_flags : reg_rdata; // [RULE10]

   assign rd_wrapping_next  = rd_start ? wrap_sel : rd_wrapping_reg;
   assign rd_wlen_next      = rd_start ? cfg_v_reg[`BWECC_WLEN_MSB:`BWECC_WLEN_LSB] : // [RULE8]
                              rd_wlen_reg;
   assign rd_byte_addr_next = rd_start ? rd_addr :
                              rd_next ? next_addr(rd_byte_addr_reg, rd_wrapping_reg, rd_wlen_reg) :
                              rd_byte_addr_reg; // [RULE16]

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         hw_sync_reg   <= 3'h7;
         hw_active_reg <= 1'b0;
      end else begin
         hw_sync_reg <= {hw_sync_reg[1:0], hw_reset_pin_n};
         // a level change only counts once the last two stages agree
         if (hw_agree) begin
            hw_active_reg <= !hw_sync_reg[2];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cfg_nv_reg <= `BWECC_CFG_RESET; // [RULE6] [RULE8] [RULE9]
         cfg_v_reg  <= `BWECC_CFG_RESET; // [RULE2]
      end else begin
         cfg_nv_reg <= cfg_nv_next;
         cfg_v_reg  <= cfg_v_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg        <= BWECC_ST_IDLE;
         ecc_query_reg    <= 1'b0;
         ecc_unit_sel_reg <= '0;
         ecc_status_reg   <= `BWECC_ECC_RESET; // [RULE11]
         rsp_valid_reg    <= 1'b0;
         rsp_data_reg     <= 8'h00;
      end else begin
         state_reg      <= state_next;
         ecc_query_reg  <= take_ecc;
         rsp_valid_reg  <= rsp_valid_next;
         rsp_data_reg   <= rsp_data_next;
         if (take_ecc) begin
            ecc_unit_sel_reg <= cmd_addr;
         end
         if (state_reg == BWECC_ST_QUERY) begin
            ecc_status_reg <= ecc_flags; // [RULE11]
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rd_byte_addr_reg <= '0;
         rd_wrapping_reg  <= 1'b0;
         rd_wlen_reg      <= 2'b00;
      end else begin
         rd_byte_addr_reg <= rd_byte_addr_next;
         rd_wrapping_reg  <= rd_wrapping_next;
         rd_wlen_reg      <= rd_wlen_next;
      end
   end

   assign cmd_busy              = ecc_query_reg;
   assign rsp_valid             = rsp_valid_reg;
   assign rsp_data              = rsp_data_reg;
   assign ecc_query             = ecc_query_reg;
   assign ecc_unit_sel          = ecc_unit_sel_reg;
   assign rd_byte_addr          = rd_byte_addr_reg;
   assign rd_wrapping           = rd_wrapping_reg;
   assign drive_strength_select = cfg_v_reg[`BWECC_DRV_MSB:`BWECC_DRV_LSB]; // [RULE3] [RULE9]
   assign boot_drive_strength   = cfg_nv_reg[`BWECC_DRV_MSB:`BWECC_DRV_LSB]; // [RULE9]

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // register commands, reset reload, wrap addressing, ecc answers and the refusal window behind an ecc read
   a_reg_read_vol: assert property (take_rd && hit_v // [RULE4]
      |=> rsp_valid && rsp_data == $past(cfg_v_reg))
      else $error("volatile config read returned wrong data");

   a_unmapped_read: assert property (take_rd && !hit_nv && !hit_v // [RULE4]
      |=> rsp_valid && rsp_data == 8'h00)
      else $error("unmapped register read returned data");

   a_reg_write_nv: assert property (take_wr && hit_nv // [RULE4]
      |=> cfg_nv_reg == ($past(cmd_wdata) & `BWECC_CFG_WMASK))
      else $error("non-volatile config write not stored");

   a_busy_refuse: assert property (cmd_valid && cmd_busy // [RULE10]
      |=> $stable(cfg_nv_reg))
      else $error("command taken while an ecc query was busy");

   a_burst_len_cmd: assert property (take_sbl && !reload_req // [RULE5]
      |=> $stable(cfg_nv_reg) && cfg_v_reg == ($past(cmd_wdata) & `BWECC_CFG_WMASK))
      else $error("burst length command handled wrongly");

   a_drive_follow: assert property (take_sbl && !reload_req // [RULE3] [RULE9]
      |=> drive_strength_select == $past(cmd_wdata[`BWECC_DRV_MSB:`BWECC_DRV_LSB]))
      else $error("drive strength did not follow the volatile copy");

   a_reset_reload: assert property (reload_req // [RULE2]
      |=> cfg_v_reg == $past(cfg_nv_reg)
          && drive_strength_select == $past(cfg_nv_reg[`BWECC_DRV_MSB:`BWECC_DRV_LSB]))
      else $error("reset did not reload volatile config");

   a_nv_keep_reload: assert property (reload_req && !(take_wr && hit_nv) // [RULE2]
      |=> $stable(cfg_nv_reg))
      else $error("reset reload disturbed the non-volatile copy");

   a_wrap_main_only: assert property (rd_start && !rd_main_array // [RULE1]
      |=> !rd_wrapping)
      else $error("wrap applied outside main array");

   a_wrap_quad_only: assert property (rd_start && !quad_op // [RULE7]
      |=> !rd_wrapping)
      else $error("wrap applied to a non quad read");

   a_wrap_enable_bit: assert property (rd_start && rd_main_array && quad_op // [RULE6]
      |=> rd_wrapping == !$past(cfg_v_reg[`BWECC_WRAP_DIS_BIT]))
      else $error("wrap enable polarity wrong");

   a_wlen_latched: assert property (rd_start // [RULE8]
      |=> rd_wlen_reg == $past(cfg_v_reg[`BWECC_WLEN_MSB:`BWECC_WLEN_LSB]))
      else $error("wrap length not taken from the volatile copy");

   a_wrap_in_block: assert property (rd_next && !rd_start && rd_wrapping // [RULE16] [RULE8]
      |=> (rd_byte_addr & ~wrap_mask(rd_wlen_reg))
          == ($past(rd_byte_addr) & ~wrap_mask(rd_wlen_reg))
          && rd_byte_addr != $past(rd_byte_addr))
      else $error("wrapped address left its block");

   a_seq_advance: assert property (rd_next && !rd_start && !rd_wrapping // [RULE16]
      |=> rd_byte_addr == $past(rd_byte_addr) + ADDR_W'(1))
      else $error("sequential read did not advance by one");

   a_ecc_answer: assert property (take_ecc // [RULE10] [RULE11]
      |=> ecc_query && ecc_unit_sel == $past(cmd_addr)
          ##1 rsp_valid && rsp_data[7:3] == 5'h00)
      else $error("ecc status answer missing");

   a_ecc_flags: assert property (ecc_query // [RULE12] [RULE13] [RULE14]
      |=> rsp_data[2:0] == $past({ecc_code_fixed, ecc_data_fixed, ecc_disabled_in}))
      else $error("ecc status bits do not match unit");

   a_ecc_status_copy: assert property (ecc_query // [RULE11]
      |=> ecc_status_reg == rsp_data)
      else $error("ecc status register lost the answered value");

   // main scenarios
   c_ecc_read: cover property (take_ecc ##2 rsp_valid);
   c_burst_len: cover property (take_sbl ##1 cfg_v_reg[`BWECC_WRAP_DIS_BIT] == 1'b0);
   c_wrap_around: cover property (rd_wrapping && rd_next
      ##1 (rd_byte_addr & wrap_mask(rd_wlen_reg)) == '0);
   c_sw_reload: cover property (sw_reset ##1 cfg_v_reg == cfg_nv_reg);
   c_hw_reload: cover property ($rose(hw_active_reg) ##1 cfg_v_reg == cfg_nv_reg);
endmodule

// [tb/bwecc_ecc_model.sv]
// ecc engine model answering unit status queries
`timescale 1ns/1ps
module bwecc_ecc_model (
   input  wire logic        ref_clk,
   input  wire logic        ecc_query,
   input  wire logic [31:0] ecc_unit_sel,
   output logic             code_fixed,
   output logic             data_fixed,
   output logic             ecc_off
);
   logic [2:0] junk_reg = 3'h2;
   // outside a query the flags move every cycle so stale values cannot pass
   always_ff @(posedge ref_clk) junk_reg <= junk_reg + 3'h5;
   assign code_fixed = ecc_query ? ecc_unit_sel[2] : junk_reg[0];
   assign data_fixed = ecc_query ? ecc_unit_sel[1] : junk_reg[1];
   assign ecc_off    = ecc_query ? ecc_unit_sel[0] : junk_reg[2];
endmodule

// [tb/test_burst_wrap_and_ecc_status_regs.sv]
// self-checking bench for the wrap configuration and ecc status registers
`timescale 1ns/1ps
`include "bwecc_defines.svh"
module test_burst_wrap_and_ecc_status_regs;
   logic        ref_clk, resetn, sw_reset, hw_reset_pin_n, cmd_valid, rd_start, rd_main_array;
   logic        rd_next, code_f, data_f, off_f, cmd_busy, rsp_valid, ecc_query, rd_wrapping;
   logic [7:0]  cmd_opcode, cmd_wdata, rd_opcode, rsp_data, nv, v;
   logic [31:0] cmd_addr, rd_addr, ecc_unit_sel, rd_byte_addr, r;
   logic [2:0]  drive_strength_select, boot_drive_strength;
   logic [15:0] exp_q[$];
   logic [15:0] note;
   int          fails = 0, n_compared = 0, seed = 33, i;

   bwecc_regs bwecc_regs_inst (.ref_clk(ref_clk), .resetn(resetn), .sw_reset(sw_reset),
      .hw_reset_pin_n(hw_reset_pin_n), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rd_start(rd_start), .rd_opcode(rd_opcode),
      .rd_main_array(rd_main_array), .rd_addr(rd_addr), .rd_next(rd_next),
      .ecc_code_fixed(code_f), .ecc_data_fixed(data_f), .ecc_disabled_in(off_f),
      .cmd_busy(cmd_busy), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .ecc_query(ecc_query),
      .ecc_unit_sel(ecc_unit_sel), .rd_byte_addr(rd_byte_addr), .rd_wrapping(rd_wrapping),
      .drive_strength_select(drive_strength_select), .boot_drive_strength(boot_drive_strength));
   bwecc_ecc_model bwecc_ecc_model_inst (.ref_clk(ref_clk), .ecc_query(ecc_query),
      .ecc_unit_sel(ecc_unit_sel), .code_fixed(code_f), .data_fixed(data_f), .ecc_off(off_f));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic cmd(input logic [7:0] op, input logic [31:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_opcode <= op;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
   endtask

   task automatic rd_reg(input logic [31:0] a, input logic [7:0] e);
      cmd(`BWECC_OP_REG_READ, a, 8'h00);
      exp_q.push_back({8'hff, e});
   endtask

   task automatic burst(input logic [7:0] op, input logic main, input logic [31:0] a,
                        input int len, input logic wr);
      logic [31:0] m;
      int          k;
      m = 32'(len - 1);
      @(posedge ref_clk);
      rd_start <= 1'b1;
      rd_opcode <= op;
      rd_main_array <= main;
      rd_addr <= a;
      @(posedge ref_clk);
      rd_start <= 1'b0;
      rd_next <= 1'b1;
      for (k = 0; k < len + 3; k++) begin
         #1;
         check(rd_byte_addr, wr ? ((a & ~m) | ((a + 32'(k)) & m)) : a + 32'(k));
         check(rd_wrapping, wr);
         @(posedge ref_clk);
      end
      rd_next <= 1'b0;
   endtask

   always @(posedge ref_clk) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("unexpected at %0t: answer with nothing pending", $time);
         end else begin
            note = exp_q.pop_front();
            check(rsp_data & note[15:8], note[7:0]);
         end
      end
   end

   initial begin
      repeat (5000) @(posedge ref_clk);
      fails++;
      close_out();
   end

   initial begin
      {resetn, sw_reset, cmd_valid, rd_start, rd_main_array, rd_next} = 6'h00;
      hw_reset_pin_n = 1'b1;
      {cmd_opcode, cmd_wdata, rd_opcode, cmd_addr, rd_addr} = 88'h0;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      rd_reg(`BWECC_ADDR_CFG_NV, `BWECC_CFG_RESET);
      rd_reg(`BWECC_ADDR_CFG_V, `BWECC_CFG_RESET);
      r = $random(seed);
      nv = r[7:0] & `BWECC_CFG_WMASK;
      v = ~r[7:0] & `BWECC_CFG_WMASK;
      cmd(`BWECC_OP_REG_WRITE, `BWECC_ADDR_CFG_NV, r[7:0]);
      cmd(`BWECC_OP_BURST_LEN, 32'h0, ~r[7:0]);
      rd_reg(`BWECC_ADDR_CFG_NV, nv);
      rd_reg(`BWECC_ADDR_CFG_V, v);
      check(drive_strength_select, v[7:5]);
      check(boot_drive_strength, nv[7:5]);
      rd_reg(32'h0000_0020, 8'h00);
      @(posedge ref_clk) sw_reset <= 1'b1;
      @(posedge ref_clk) sw_reset <= 1'b0;
      rd_reg(`BWECC_ADDR_CFG_V, nv);
      cmd(`BWECC_OP_BURST_LEN, 32'h0, v);
      @(posedge ref_clk) hw_reset_pin_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      hw_reset_pin_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd_reg(`BWECC_ADDR_CFG_V, nv);
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         cmd(i[0] ? `BWECC_OP_ECC_READ_B : `BWECC_OP_ECC_READ_A, r, 8'h00);
         exp_q.push_back({8'h07, 5'h00, r[2:0]});
         #1;
         check({cmd_busy, ecc_query}, 32'h3);
         check(ecc_unit_sel, r);
      end
      // a write landing in the busy cycle after an ecc read must be dropped
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_opcode <= `BWECC_OP_ECC_READ_A;
      cmd_addr <= 32'h5;
      @(posedge ref_clk);
      cmd_opcode <= `BWECC_OP_REG_WRITE;
      cmd_addr <= `BWECC_ADDR_CFG_NV;
      cmd_wdata <= ~nv;
      exp_q.push_back({8'h07, 8'h05});
      @(posedge ref_clk) cmd_valid <= 1'b0;
      rd_reg(`BWECC_ADDR_CFG_NV, nv);
      for (i = 0; i < 4; i++) begin
         cmd(`BWECC_OP_BURST_LEN, 32'h0, 8'(i));
         burst(i[0] ? `BWECC_OP_DDR_QIO_READ : `BWECC_OP_QUAD_IO_READ, 1'b1,
               32'h0000_013e - 32'(i), 8 << i, 1'b1);
      end
      burst(8'h0b, 1'b1, 32'h3e, 8, 1'b0);
      burst(`BWECC_OP_QUAD_IO_READ, 1'b0, 32'h3e, 8, 1'b0);
      cmd(`BWECC_OP_BURST_LEN, 32'h0, 8'h10);
      burst(`BWECC_OP_QUAD_IO_READ, 1'b1, 32'h3e, 8, 1'b0);
      repeat (4) @(posedge ref_clk);
      check(exp_q.size(), 32'h0);
      close_out();
   end
endmodule
